//--- verilog/gsm_top.sv
// six general purpose pins with ownership priority and a serial master
// assumes pins are resolved outside from out/oe/pull; spi_clk is the link clock
//
// Overview of operation
// - six pins, each set as input or output by software
// - pull select picks push-pull, weak pullup or weak pulldown
// - enabled fault level on a pin sets its sticky fault flag
// - pin level status always shows every pin's present level
// - an output pin drives its output level bit
// - enabled serial master owns pins 3 to 6, ignoring their config
// - address strap makes a pin an input, ignoring its config
// - pull select zero makes the pin an ADC input
// - otherwise pin follows function select and fault enable
// - temperature comparator faults flag regardless of pin ownership
// - serial master: pin 3 is select, pin 6 is clock
// - serial master uses clock, data out, data in and select
// - polarity sets clock idle level, low for 0, high for 1
// - phase 0: data valid before first edge, sampled leading, changed trailing
// - phase 1: data launched on first edge, sampled on trailing
// - bit count gives 1 to 8 bits, sampled only at launch
// - execute runs one full-duplex transfer of transmit into receive
// - short transfers use and update only the low-order bits
// - select holds software level across transfers for chaining
// - pins 3 to 6 follow pin config until the serial master is enabled
module gsm_top (
    // clocks and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic spi_clk,
    // configuration
    input wire gsm_pkg::gsm_pin_cfg_t [gsm_pkg::NUM_PINS-1:0] pin_config,
    input wire logic [gsm_pkg::NUM_PINS-1:0] out_level,
    input wire gsm_pkg::gsm_spi_cfg_t spi_config,
    input wire logic [7:0] tx_data,
    input wire logic serial_execute,
    // fault control
    input wire logic [gsm_pkg::NUM_PINS-1:0] fault_clear,
    input wire logic [gsm_pkg::NUM_PINS-1:0] temperature_comparator_en,
    input wire logic [gsm_pkg::NUM_PINS-1:0] temperature_comparator_trip,
    input wire logic [gsm_pkg::NUM_PINS-1:0] temp_fault_clear,
    // pins
    input wire logic [gsm_pkg::NUM_PINS-1:0] pin_in,
    output logic [gsm_pkg::NUM_PINS-1:0] pin_out,
    output logic [gsm_pkg::NUM_PINS-1:0] pin_oe,
    output logic [gsm_pkg::NUM_PINS-1:0] pin_pullup,
    output logic [gsm_pkg::NUM_PINS-1:0] pin_pulldown,
    output logic [gsm_pkg::NUM_PINS-1:0] pin_adc_sel,
    // status
    output logic [gsm_pkg::NUM_PINS-1:0] pin_level,
    output logic [gsm_pkg::NUM_PINS-1:0] fault_flag,
    output logic [gsm_pkg::NUM_PINS-1:0] temp_fault_flag,
    output logic [7:0] rx_data,
    output logic busy
);

    ////////////////////////////////////////////////////////////////////////////
    // decoding helpers

    function automatic logic [3:0] count_decode(input logic [2:0] f);
        count_decode = (f == 3'h0) ? gsm_pkg::FULL_BYTE : {1'b0, f};
    endfunction

    function automatic logic [7:0] count_mask(input logic [3:0] n);
        logic [8:0] one_hot;
        one_hot = 9'h001 << n;
        count_mask = 8'(one_hot - 9'h001);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // reset release, one copy per clock domain

    logic [1:0] rst_sync_q;
    logic [1:0] lrst_sync_q;
    logic rst_n;
    logic lrst_n;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) rst_sync_q <= 2'h0;
        else rst_sync_q <= {rst_sync_q[0], 1'b1};
    end

    always_ff @(posedge spi_clk or negedge rst_b) begin
        if (!rst_b) lrst_sync_q <= 2'h0;
        else lrst_sync_q <= {lrst_sync_q[0], 1'b1};
    end

    assign rst_n = rst_sync_q[1];
    assign lrst_n = lrst_sync_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // pin and comparator synchronisers

    logic [gsm_pkg::NUM_PINS-1:0] pin_meta_q;
    logic [gsm_pkg::NUM_PINS-1:0] pin_sync_q;
    logic [gsm_pkg::NUM_PINS-1:0] trip_meta_q;
    logic [gsm_pkg::NUM_PINS-1:0] trip_sync_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_q <= 6'h00;
            pin_sync_q <= 6'h00;
            trip_meta_q <= 6'h00;
            trip_sync_q <= 6'h00;
        end else begin
            pin_meta_q <= pin_in;
            pin_sync_q <= pin_meta_q;
            trip_meta_q <= temperature_comparator_trip;
            trip_sync_q <= trip_meta_q;
        end
    end

    assign pin_level = pin_sync_q;

    ////////////////////////////////////////////////////////////////////////////
    // pin ownership and drive

    logic sclk_q;
    logic mosi_q;
    logic [gsm_pkg::NUM_PINS-1:0] fault_hit;
    logic [gsm_pkg::NUM_PINS-1:0] temp_hit;

    genvar gi;
    generate
        for (gi = 0; gi < gsm_pkg::NUM_PINS; gi++) begin : g_pin
            wire spi_pin = (gi >= gsm_pkg::PIN_SEL);
            wire spi_own = spi_config.enable && spi_pin;
            wire strap = !spi_own && pin_config[gi].addr_sel;
            wire adc = !spi_own && !strap
                && (pin_config[gi].pull_select == gsm_pkg::PULL_ADC);
            wire normal = !spi_own && !strap && !adc;
            wire [2:0] ps = pin_config[gi].pull_select;
            wire [1:0] fe = pin_config[gi].pin_fault_enable_alt;
            wire spi_drv = (gi != gsm_pkg::PIN_MISO);
            wire spi_val = (gi == gsm_pkg::PIN_SEL) ? spi_config.sel_level
                : (gi == gsm_pkg::PIN_SCLK) ? sclk_q
                : mosi_q;

            assign pin_oe[gi] = spi_own ? spi_drv : (normal && pin_config[gi].out_dir);
            assign pin_out[gi] = spi_own ? spi_val : out_level[gi];
            assign pin_pullup[gi] = normal && (ps == gsm_pkg::PULL_UP);
            assign pin_pulldown[gi] = normal && (ps == gsm_pkg::PULL_DOWN);
            assign pin_adc_sel[gi] = adc;
            // fault detection ignores function select but not higher owners
            assign fault_hit[gi] = !spi_own && !strap
                && (((fe == gsm_pkg::FAULT_HIGH) && pin_sync_q[gi])
                || ((fe == gsm_pkg::FAULT_LOW) && !pin_sync_q[gi]));
            // comparator watches the pin whoever owns it
            assign temp_hit[gi] = temperature_comparator_en[gi] && trip_sync_q[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // sticky fault flags, a new hit beats a clear in the same cycle

    logic [gsm_pkg::NUM_PINS-1:0] fault_q;
    logic [gsm_pkg::NUM_PINS-1:0] fault_d;
    logic [gsm_pkg::NUM_PINS-1:0] temp_q;
    logic [gsm_pkg::NUM_PINS-1:0] temp_d;

    assign fault_d = (fault_q & ~fault_clear) | fault_hit;
    assign temp_d = (temp_q & ~temp_fault_clear) | temp_hit;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_q <= gsm_pkg::FLAG_RESET;
            temp_q <= gsm_pkg::FLAG_RESET;
        end else begin
            fault_q <= fault_d;
            temp_q <= temp_d;
        end
    end

    assign fault_flag = fault_q;
    assign temp_fault_flag = temp_q;

    ////////////////////////////////////////////////////////////////////////////
    // transfer launch and completion, system side

    gsm_pkg::gsm_spi_cmd_t cmd_q;
    gsm_pkg::gsm_spi_cmd_t cmd_d;
    logic go_tgl_q;
    logic busy_q;
    logic [7:0] rx_q;
    logic [7:0] rx_d;
    logic [2:0] done_sync_q;
    logic done_tgl_q;
    logic [7:0] lrx_q;
    logic launch;
    logic done_pulse;
    logic [7:0] rx_mask;

    // execute is dropped while a transfer is running or the master is off
    assign launch = serial_execute && spi_config.enable && !busy_q;
    assign done_pulse = done_sync_q[2] ^ done_sync_q[1];
    assign cmd_d = launch ? {spi_config.cpol, spi_config.cpha,
        count_decode(spi_config.transfer_bit_count), tx_data} : cmd_q;
    assign rx_mask = count_mask(cmd_q.nbits);
    // link result is stable once its done toggle has crossed
    assign rx_d = done_pulse ? ((rx_q & ~rx_mask) | (lrx_q & rx_mask)) : rx_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_q <= '0;
            go_tgl_q <= 1'b0;
            busy_q <= 1'b0;
            rx_q <= gsm_pkg::RX_RESET;
            done_sync_q <= 3'h0;
        end else begin
            cmd_q <= cmd_d;
            go_tgl_q <= go_tgl_q ^ launch;
            busy_q <= launch | (busy_q & !done_pulse);
            rx_q <= rx_d;
            done_sync_q <= {done_sync_q[1:0], done_tgl_q};
        end
    end

    assign rx_data = rx_q;
    assign busy = busy_q;

    ////////////////////////////////////////////////////////////////////////////
    // link side crossings

    logic [2:0] go_sync_q;
    logic [1:0] cpol_sync_q;
    logic [1:0] miso_sync_q;
    logic go_pulse;
    logic miso_s;

    always_ff @(posedge spi_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            go_sync_q <= 3'h0;
            cpol_sync_q <= 2'h0;
            miso_sync_q <= 2'h0;
        end else begin
            go_sync_q <= {go_sync_q[1:0], go_tgl_q};
            cpol_sync_q <= {cpol_sync_q[0], spi_config.cpol};
            miso_sync_q <= {miso_sync_q[0], pin_in[gsm_pkg::PIN_MISO]};
        end
    end

    assign go_pulse = go_sync_q[2] ^ go_sync_q[1];
    assign miso_s = miso_sync_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // serial engine on the link clock

    gsm_pkg::gsm_link_state_t st_q;
    gsm_pkg::gsm_link_state_t st_d;
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    logic [3:0] left_q;
    logic [3:0] left_d;
    logic [7:0] sh_q;
    logic [7:0] sh_d;
    logic [7:0] lrx_d;
    logic sclk_d;
    logic mosi_d;
    logic done_d;
    logic half_end;
    logic sample;
    logic [3:0] shamt;
    logic [7:0] sh_load;

    assign half_end = (cnt_q == gsm_pkg::HALF_LAST);
    // miso is two flops late, so it is taken mid-half rather than on the edge
    assign sample = (cnt_q == gsm_pkg::SAMPLE_AT);
    // short words are left-aligned so the top bit goes first
    assign shamt = gsm_pkg::FULL_BYTE - cmd_q.nbits;
    assign sh_load = 8'(cmd_q.tx << shamt);

    always_comb begin
        st_d = st_q;
        cnt_d = half_end ? 3'h0 : 3'(cnt_q + 3'h1);
        left_d = left_q;
        sh_d = sh_q;
        lrx_d = lrx_q;
        sclk_d = sclk_q;
        mosi_d = mosi_q;
        done_d = done_tgl_q;
        case (st_q)
            gsm_pkg::L_IDLE: begin
                cnt_d = 3'h0;
                sclk_d = cpol_sync_q[1];
                if (go_pulse) begin
                    st_d = gsm_pkg::L_SETUP;
                    sh_d = sh_load;
                    left_d = cmd_q.nbits;
                    sclk_d = cmd_q.cpol;
                    if (!cmd_q.cpha) mosi_d = sh_load[7];
                end
            end
            gsm_pkg::L_SETUP: begin
                if (half_end) begin
                    st_d = gsm_pkg::L_LEAD;
                    sclk_d = !cmd_q.cpol;
                    if (cmd_q.cpha) mosi_d = sh_q[7];
                end
            end
            gsm_pkg::L_LEAD: begin
                if (sample && !cmd_q.cpha) lrx_d = {lrx_q[6:0], miso_s};
                if (half_end) begin
                    st_d = gsm_pkg::L_TRAIL;
                    sclk_d = cmd_q.cpol;
                    if (!cmd_q.cpha) begin
                        mosi_d = sh_q[6];
                        sh_d = {sh_q[6:0], 1'b0};
                    end
                end
            end
            gsm_pkg::L_TRAIL: begin
                if (sample && cmd_q.cpha) lrx_d = {lrx_q[6:0], miso_s};
                if (half_end) begin
                    left_d = 4'(left_q - 4'h1);
                    if (left_q == 4'h1) begin
                        st_d = gsm_pkg::L_DONE;
                    end else begin
                        st_d = gsm_pkg::L_LEAD;
                        sclk_d = !cmd_q.cpol;
                        if (cmd_q.cpha) begin
                            mosi_d = sh_q[6];
                            sh_d = {sh_q[6:0], 1'b0};
                        end
                    end
                end
            end
            gsm_pkg::L_DONE: begin
                // half period of idle clock before the result is released
                if (half_end) begin
                    st_d = gsm_pkg::L_IDLE;
                    done_d = !done_tgl_q;
                end
            end
            default: begin
                st_d = gsm_pkg::L_IDLE;
            end
        endcase
    end

    always_ff @(posedge spi_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            st_q <= gsm_pkg::L_IDLE;
            cnt_q <= 3'h0;
            left_q <= 4'h0;
            sh_q <= 8'h00;
            lrx_q <= gsm_pkg::RX_RESET;
            sclk_q <= 1'b0;
            mosi_q <= 1'b0;
            done_tgl_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            left_q <= left_d;
            sh_q <= sh_d;
            lrx_q <= lrx_d;
            sclk_q <= sclk_d;
            mosi_q <= mosi_d;
            done_tgl_q <= done_d;
        end
    end

endmodule

//--- verilog/gsm_pkg.sv
// shared types and constants for the six-pin general purpose block and its serial master
// assumes a 100 MHz system clock and a separate link clock for the serial engine
package gsm_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // pin count and the pins taken over by the serial master
    localparam int NUM_PINS = 6;
    localparam int PIN_SEL = 2;
    localparam int PIN_MOSI = 3;
    localparam int PIN_MISO = 4;
    localparam int PIN_SCLK = 5;

    ////////////////////////////////////////////////////////////////////////////
    // pull select codes
    localparam logic [2:0] PULL_ADC = 3'h0;
    localparam logic [2:0] PULL_PUSH = 3'h1;
    localparam logic [2:0] PULL_UP = 3'h2;
    localparam logic [2:0] PULL_DOWN = 3'h3;

    // fault enable codes
    localparam logic [1:0] FAULT_OFF = 2'h0;
    localparam logic [1:0] FAULT_HIGH = 2'h1;
    localparam logic [1:0] FAULT_LOW = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // serial engine timing in link clock cycles, and the full word length in bits
    localparam logic [2:0] HALF_LAST = 3'h3;
    localparam logic [2:0] SAMPLE_AT = 3'h2;
    localparam logic [3:0] FULL_BYTE = 4'h8;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] RX_RESET = 8'h00;
    localparam logic [5:0] FLAG_RESET = 6'h00;

    ////////////////////////////////////////////////////////////////////////////
    // one pin configuration
    typedef struct packed {
        logic addr_sel;
        logic [2:0] pull_select;
        logic [1:0] pin_fault_enable_alt;
        logic out_dir;
    } gsm_pin_cfg_t;

    // serial master configuration
    typedef struct packed {
        logic enable;
        logic sel_level;
        logic cpol;
        logic cpha;
        logic [2:0] transfer_bit_count;
    } gsm_spi_cfg_t;

    // transfer snapshot handed to the link domain
    typedef struct packed {
        logic cpol;
        logic cpha;
        logic [3:0] nbits;
        logic [7:0] tx;
    } gsm_spi_cmd_t;

    // link engine states
    typedef enum logic [4:0] {
        L_IDLE = 5'h01,
        L_SETUP = 5'h02,
        L_LEAD = 5'h04,
        L_TRAIL = 5'h08,
        L_DONE = 5'h10
    } gsm_link_state_t;

endpackage

//--- test/gsm_spi_slave.sv
// far-side serial slave: shifts a byte out while collecting what it hears
// assumes an active low select; the clock is ignored while deselected
module gsm_spi_slave (
    // serial lines
    input wire logic sclk,
    input wire logic mosi,
    input wire logic sel_b,
    output logic miso,
    // mode and data
    input wire logic cpol,
    input wire logic cpha,
    input wire logic [7:0] tx_byte,
    output logic [7:0] rx_byte
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] sh_q = 8'h00;
    logic bit_q = 1'b0;
    initial rx_byte = 8'h00;
    // released line shows the inverse, so a stale bit never passes
    assign miso = sel_b ? ~bit_q : bit_q;
    always @(negedge sel_b) begin
        sh_q = tx_byte;
        bit_q = cpha ? ~tx_byte[7] : tx_byte[7];
    end
    // shifting continues while selected, so transfers chain
    always @(sclk) begin
        if (!sel_b && sclk === ~cpol) begin
            if (cpha) begin
                bit_q = sh_q[7];
                sh_q = sh_q << 1;
            end else begin
                rx_byte = {rx_byte[6:0], mosi};
            end
        end else if (!sel_b && sclk === cpol) begin
            if (cpha) begin
                rx_byte = {rx_byte[6:0], mosi};
            end else begin
                sh_q = sh_q << 1;
                bit_q = sh_q[7];
            end
        end
    end
endmodule

//--- test/gsm_top_checker.sv
// concurrent checks on the ports of the six-pin block
// assumes it is bound into gsm_top; all checks run on ref_clk
module gsm_top_checker (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // controls
    input wire gsm_pkg::gsm_pin_cfg_t [gsm_pkg::NUM_PINS-1:0] pin_config,
    input wire gsm_pkg::gsm_spi_cfg_t spi_config,
    input wire logic serial_execute,
    input wire logic [gsm_pkg::NUM_PINS-1:0] fault_clear,
    input wire logic [gsm_pkg::NUM_PINS-1:0] temperature_comparator_en,
    input wire logic [gsm_pkg::NUM_PINS-1:0] temperature_comparator_trip,
    // pins and status
    input wire logic [gsm_pkg::NUM_PINS-1:0] pin_in,
    input wire logic [gsm_pkg::NUM_PINS-1:0] pin_out,
    input wire logic [gsm_pkg::NUM_PINS-1:0] pin_oe,
    input wire logic [gsm_pkg::NUM_PINS-1:0] pin_pullup,
    input wire logic [gsm_pkg::NUM_PINS-1:0] pin_pulldown,
    input wire logic [gsm_pkg::NUM_PINS-1:0] pin_adc_sel,
    input wire logic [gsm_pkg::NUM_PINS-1:0] pin_level,
    input wire logic [gsm_pkg::NUM_PINS-1:0] fault_flag,
    input wire logic [gsm_pkg::NUM_PINS-1:0] temp_fault_flag,
    input wire logic [7:0] rx_data,
    input wire logic busy
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    logic en_w;
    assign en_w = spi_config.enable;
    ////////////////////////////////////////////////////////////////////////////
    sel_pin_a: assert property (en_w |-> pin_oe[2] && pin_out[2] == spi_config.sel_level)
        else $error("select pin wrong");
    spi_own_a: assert property (en_w |-> pin_oe[3] && pin_oe[5] && !pin_oe[4]
        && pin_pullup[5:2] == 4'h0 && pin_pulldown[5:2] == 4'h0) else $error("pins not owned");
    sclk_idle_a: assert property (en_w && $fell(busy) |-> pin_out[5] == spi_config.cpol)
        else $error("clock idle level");
    rx_update_a: assert property ($changed(rx_data) |-> $fell(busy))
        else $error("receive changed outside completion");
    go_start_a: assert property (serial_execute && en_w && !busy |=> busy)
        else $error("launch missed");
    go_refuse_a: assert property (serial_execute && !en_w && !busy |=> !busy)
        else $error("launch while disabled");
    // six cycles leave room for the internal reset release
    fault_set_a: assert property ((!pin_config[0].addr_sel && pin_in[0]
        && pin_config[0].pin_fault_enable_alt == gsm_pkg::FAULT_HIGH) [*6] |=> fault_flag[0])
        else $error("fault flag not set");
    fault_keep_a: assert property (fault_flag[0] && !fault_clear[0] |=> fault_flag[0])
        else $error("fault flag lost");
    level_track_a: assert property ($stable(pin_in) [*8] |-> pin_level == pin_in)
        else $error("level status stale");
    temp_flag_a: assert property ((temperature_comparator_en[5]
        && temperature_comparator_trip[5]) [*6] |=> temp_fault_flag[5]) else $error("temp flag");
    strap_in_a: assert property (pin_config[0].addr_sel |-> !pin_oe[0] && !pin_pullup[0])
        else $error("strap pin driven");
    adc_pin_a: assert property (!pin_config[1].addr_sel
        && pin_config[1].pull_select == gsm_pkg::PULL_ADC |-> pin_adc_sel[1] && !pin_oe[1])
        else $error("adc pin");
    cover property ($fell(busy) && spi_config.cpha);
    cover property ($rose(fault_flag[0]));
    cover property ($rose(temp_fault_flag[5]));
endmodule
bind gsm_top gsm_top_checker i_chk (.ref_clk, .rst_b, .pin_config, .spi_config, .serial_execute,
    .fault_clear, .temperature_comparator_en, .temperature_comparator_trip, .pin_in, .pin_out,
    .pin_oe, .pin_pullup, .pin_pulldown, .pin_adc_sel, .pin_level, .fault_flag,
    .temp_fault_flag, .rx_data, .busy);

//--- test/gsm_top_tb.sv
// self-checking bench for the six-pin block and its serial master
// assumes gsm_top, its checker and the slave model are compiled first
module gsm_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        gsm_pkg::gsm_pin_cfg_t cfg;
        logic lvl;
        logic [4:0] exp;
    } gsm_row_t;
    logic ref_clk = 1'b0;
    logic spi_clk = 1'b0;
    logic rst_b = 1'b0;
    gsm_pkg::gsm_pin_cfg_t [5:0] pin_config = '0;
    gsm_pkg::gsm_spi_cfg_t spi_config = '0;
    logic [5:0] out_level = '0, fault_clear = '0, tc_en = '0, tc_trip = '0, tc_clr = '0;
    logic [5:0] ext_q = '0, wire_lvl, pin_in, pin_out, pin_oe, pull_up, pull_dn, adc;
    logic [5:0] pin_level, fault_flag, temp_fault_flag, lvl_exp;
    logic [4:0] row_got;
    logic [7:0] tx_data = 8'h00, slave_tx = 8'h3C, rx_data, slave_rx;
    logic serial_execute = 1'b0;
    logic busy, miso_w;
    int mismatches = 0;
    int cmp_count = 0;
    // exp is {oe, out, pullup, pulldown, adc}
    gsm_row_t rows [6] = '{
        {1'b0, gsm_pkg::PULL_PUSH, 2'h0, 1'b1, 1'b1, 5'h18},
        {1'b0, gsm_pkg::PULL_UP, 2'h0, 1'b1, 1'b0, 5'h14},
        {1'b0, gsm_pkg::PULL_UP, 2'h0, 1'b0, 1'b1, 5'h04},
        {1'b0, gsm_pkg::PULL_DOWN, 2'h0, 1'b0, 1'b0, 5'h02},
        {1'b0, gsm_pkg::PULL_ADC, 2'h0, 1'b1, 1'b1, 5'h01},
        {1'b1, gsm_pkg::PULL_UP, 2'h0, 1'b1, 1'b1, 5'h00}};
    ////////////////////////////////////////////////////////////////////////////
    assign wire_lvl = {ext_q[5], spi_config.enable ? miso_w : ext_q[4], ext_q[3:0]};
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & wire_lvl);
    initial forever #5 ref_clk = ~ref_clk;
    initial begin
        #7;
        forever #16 spi_clk = ~spi_clk;
    end
    gsm_top i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .spi_clk(spi_clk), .pin_config(pin_config),
        .out_level(out_level), .spi_config(spi_config), .tx_data(tx_data),
        .serial_execute(serial_execute), .fault_clear(fault_clear),
        .temperature_comparator_en(tc_en), .temperature_comparator_trip(tc_trip),
        .temp_fault_clear(tc_clr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pull_up), .pin_pulldown(pull_dn), .pin_adc_sel(adc), .pin_level(pin_level),
        .fault_flag(fault_flag), .temp_fault_flag(temp_fault_flag), .rx_data(rx_data),
        .busy(busy));
    gsm_spi_slave i_slave (.sclk(pin_in[5]), .mosi(pin_in[3]), .sel_b(pin_in[2]),
        .miso(miso_w), .cpol(spi_config.cpol), .cpha(spi_config.cpha), .tx_byte(slave_tx),
        .rx_byte(slave_rx));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results();
        if (mismatches == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic pulse();
        serial_execute = 1'b1;
        cyc(1);
        serial_execute = 1'b0;
    endtask
    task automatic wait_busy(input logic lvl, input int lim);
        for (int n = 0; busy !== lvl; n++) begin
            if (n > lim) begin
                check({7'h00, busy}, {7'h00, lvl});
                results();
            end
            cyc(1);
        end
    endtask
    task automatic xfer(input logic pol, input logic pha, input logic [2:0] cnt,
        input logic [7:0] tx);
        spi_config = '{1'b1, 1'b1, pol, pha, cnt};
        tx_data = tx;
        cyc(16);
        spi_config.sel_level = 1'b0;
        cyc(2);
        pulse();
        wait_busy(1'b1, 4);
        // one edge between the two strobes keeps each execute a clean pulse
        cyc(1);
        spi_config.transfer_bit_count = 3'h1;
        pulse();
        wait_busy(1'b0, 400);
        cyc(3);
        check({7'h00, busy}, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(6);
        rst_b = 1'b1;
        cyc(4);
        check(rx_data, gsm_pkg::RX_RESET);
        foreach (rows[i]) begin
            pin_config = {6{rows[i].cfg}};
            out_level = {6{rows[i].lvl}};
            ext_q = 6'h2A ^ {6{rows[i].lvl}};
            cyc(10);
            for (int p = 0; p < 6; p++) begin
                row_got = {pin_oe[p], pin_out[p] & rows[i].exp[4], pull_up[p], pull_dn[p], adc[p]};
                check(row_got, rows[i].exp);
            end
            lvl_exp = ({6{rows[i].exp[4]}} & out_level) | ({6{~rows[i].exp[4]}} & ext_q);
            check(pin_level, lvl_exp);
        end
        pin_config[0] = {1'b0, gsm_pkg::PULL_UP, gsm_pkg::FAULT_HIGH, 1'b0};
        pin_config[1] = {1'b0, gsm_pkg::PULL_UP, gsm_pkg::FAULT_LOW, 1'b0};
        pin_config[2] = {1'b1, gsm_pkg::PULL_UP, gsm_pkg::FAULT_HIGH, 1'b0};
        pin_config[5:3] = '0;
        ext_q = 6'h05;
        cyc(8);
        check({2'h0, fault_flag}, 8'h03);
        ext_q = 6'h02;
        cyc(8);
        fault_clear = 6'h01;
        cyc(1);
        fault_clear = '0;
        cyc(2);
        check({2'h0, fault_flag}, 8'h02);
        spi_config = '{1'b1, 1'b1, 1'b0, 1'b0, 3'h0};
        pin_config[5] = {1'b0, gsm_pkg::PULL_UP, gsm_pkg::FAULT_HIGH, 1'b0};
        tc_en = 6'h20;
        tc_trip = 6'h20;
        cyc(16);
        check({pin_oe, pin_out[2], pin_out[5]}, 8'hB2);
        check({pull_up, pull_dn[5:4]}, 8'h0C);
        check({2'h0, temp_fault_flag}, 8'h20);
        // clear while the comparator still trips: the new hit must win
        tc_clr = 6'h20;
        cyc(1);
        tc_clr = '0;
        check({2'h0, temp_fault_flag}, 8'h20);
        tc_trip = '0;
        cyc(4);
        tc_clr = 6'h20;
        cyc(1);
        tc_clr = '0;
        check({2'h0, temp_fault_flag}, 8'h00);
        for (int m = 0; m < 4; m++) begin
            slave_tx = 8'h3C ^ m[7:0];
            xfer(m[1], m[0], 3'h0, 8'hA5 ^ m[7:0]);
            check(rx_data, slave_tx);
            check(slave_rx, 8'hA5 ^ m[7:0]);
        end
        slave_tx = 8'h96;
        xfer(1'b0, 1'b0, 3'h3, 8'h0B);
        check(rx_data, 8'h3C);
        check({5'h00, slave_rx[2:0]}, 8'h03);
        xfer(1'b1, 1'b1, 3'h1, 8'h01);
        check(rx_data, 8'h3D);
        check({7'h00, slave_rx[0]}, 8'h01);
        spi_config.enable = 1'b0;
        cyc(2);
        pulse();
        cyc(2);
        check({7'h00, busy}, 8'h00);
        results();
    end
endmodule
